// ===== src/iod_core_end.sv
// Processor core end: issues I/O and data-space accesses on iod_if.
// Assumes the I/O end answers each request on the following edge.
`timescale 1ns/10ps
`include "iod_cfg.svh"

module iod_core_end #(
  parameter logic [511:0] RSV_BITS = `IOD_RSV_BITS_DEF,
  parameter logic [63:0] RSV_ADDR = `IOD_RSV_ADDR_DEF
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  iod_if.core bus,
  input wire logic cmd_valid_in,
  input wire iod_pkg::iod_op_e cmd_op_in,
  input wire logic [15:0] cmd_addr_in,
  input wire logic [7:0] cmd_wdata_in,
  input wire logic [2:0] cmd_bit_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic skip_out,
  output logic err_out
);

  iod_pkg::iod_core_state_e state;
  iod_pkg::iod_dec_s dec;
  logic take;
  logic drop;
  logic req_q;
  iod_pkg::iod_op_e op_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [2:0] bitn_q;

  // ********************************
  // Command decode
  // ********************************
  assign dec = iod_pkg::iod_decode(cmd_op_in, cmd_addr_in);
  assign cmd_ready_out = (state == iod_pkg::IOD_IDLE);
  assign take = cmd_valid_in && cmd_ready_out;
  // Stopped here so the far end never sees such a write
  assign drop = take && iod_pkg::iod_is_write(cmd_op_in) && dec.hit &&
                RSV_ADDR[dec.idx];

  // ********************************
  // Request and answer
  // ********************************
  always_ff @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      state <= iod_pkg::IOD_IDLE;
      req_q <= 1'b0;
      op_q <= iod_pkg::IOD_PORT_IN;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      bitn_q <= 3'h0;
    end
    else
    begin
      req_q <= take && !drop;
      if (take)
      begin
        op_q <= cmd_op_in;
        addr_q <= cmd_addr_in;
        // Reserved bits go out as zero for forward compatibility
        wdata_q <= cmd_wdata_in & ~RSV_BITS[{dec.idx, 3'b000} +: 8];
        bitn_q <= cmd_bit_in;
      end
      unique case (state)
        iod_pkg::IOD_IDLE:
          if (take && !drop)
            state <= iod_pkg::IOD_WAIT;
        iod_pkg::IOD_WAIT:
          if (bus.ack)
            state <= iod_pkg::IOD_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      done_out <= 1'b0;
      rdata_out <= 8'h00;
      skip_out <= 1'b0;
      err_out <= 1'b0;
    end
    else
    begin
      done_out <= drop || ((state == iod_pkg::IOD_WAIT) && bus.ack);
      if (drop)
      begin
        rdata_out <= 8'h00;
        skip_out <= 1'b0;
        err_out <= 1'b1;
      end
      else if ((state == iod_pkg::IOD_WAIT) && bus.ack)
      begin
        rdata_out <= bus.rdata;
        skip_out <= bus.skip;
        err_out <= bus.err;
      end
    end
  end

  assign bus.req = req_q;
  assign bus.op = op_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.bitn = bitn_q;

endmodule : iod_core_end

// ===== src/iod_cfg.svh
// Constants for the I/O space access decoder, both ends.
// Assumes one system clock and one synchronous active-low reset.
// Function
// - All peripheral registers live in I/O space
// - Port instructions use 6-bit addresses 0x00-0x3F
// - Data space address is I/O address plus 0x20
// - Bit set/clear only on 0x00-0x1F
// - Skip instructions test bits in lower range
// - Writing one clears flag, zero keeps it
// - Bit operations rewrite whole register, clearing flags
// - Software writes zero to reserved bits
// - Never write reserved I/O addresses
// - Reserved bits always read as zero
`ifndef IOD_CFG_SVH
`define IOD_CFG_SVH

// ********************************
// Address map
// ********************************
`define IOD_ADDR_W 16
`define IOD_NREG 64
`define IOD_IO_LAST 16'h003f
`define IOD_DATA_OFS 16'h0020
`define IOD_BIT_LAST 16'h001f

// ********************************
// Reset and default masks
// ********************************
`define IOD_RST_VAL 8'h00
`define IOD_W1C_DEF {8'hff, 8'h00, 8'hff, 8'h00, {60{8'h00}}}
`define IOD_RSV_BITS_DEF {8'h00, 8'hf0, 8'h00, 8'h00, {60{8'h00}}}
`define IOD_RSV_ADDR_DEF 64'h0000_0000_0000_0001

`endif

// ===== src/iod_pkg.sv
// Types and shared decode functions for the I/O space access decoder.
// Assumes iod_cfg.svh is on the include path.
`include "iod_cfg.svh"

package iod_pkg;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [2:0]
  {
    IOD_PORT_IN,
    IOD_PORT_OUT,
    IOD_DATA_LOAD,
    IOD_DATA_STORE,
    IOD_BIT_SET,
    IOD_BIT_CLEAR,
    IOD_SKIP_SET,
    IOD_SKIP_CLEAR
  } iod_op_e;

  typedef enum logic
  {
    IOD_IDLE,
    IOD_WAIT
  } iod_core_state_e;

  typedef struct packed
  {
    logic hit;
    logic [5:0] idx;
  } iod_dec_s;

  // ********************************
  // Functions
  // ********************************
  function automatic iod_dec_s iod_decode(input iod_op_e op,
                                          input logic [15:0] addr);
    iod_dec_s d;
    logic [15:0] rel;
    rel = addr - `IOD_DATA_OFS;
    d.hit = 1'b0;
    d.idx = addr[5:0];
    unique case (op)
      IOD_PORT_IN, IOD_PORT_OUT:
        d.hit = (addr <= `IOD_IO_LAST);
      IOD_DATA_LOAD, IOD_DATA_STORE:
      begin
        d.hit = (rel <= `IOD_IO_LAST);
        d.idx = rel[5:0];
      end
      IOD_BIT_SET, IOD_BIT_CLEAR, IOD_SKIP_SET, IOD_SKIP_CLEAR:
        d.hit = (addr <= `IOD_BIT_LAST);
    endcase
    return d;
  endfunction : iod_decode

  function automatic logic iod_is_write(input iod_op_e op);
    return (op == IOD_PORT_OUT) || (op == IOD_DATA_STORE) ||
           (op == IOD_BIT_SET) || (op == IOD_BIT_CLEAR);
  endfunction : iod_is_write

endpackage : iod_pkg

// ===== src/iod_if.sv
// Access channel between the processor core end and the I/O space end.
// Assumes both ends share one clock; no clocking here.
`timescale 1ns/10ps

interface iod_if;
  logic req;
  iod_pkg::iod_op_e op;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [2:0] bitn;
  logic ack;
  logic [7:0] rdata;
  logic skip;
  logic err;

  modport core
  (
    output req, op, addr, wdata, bitn,
    input ack, rdata, skip, err
  );

  modport io
  (
    input req, op, addr, wdata, bitn,
    output ack, rdata, skip, err
  );
endinterface : iod_if

// ===== src/iod_io_end.sv
// I/O space end: decoder and 64-register bank seen by the core.
// Assumes the core end issues one request at a time on iod_if.
`timescale 1ns/10ps
`include "iod_cfg.svh"

module iod_io_end #(
  parameter int NREG = `IOD_NREG,
  parameter logic [511:0] W1C_MASK = `IOD_W1C_DEF,
  parameter logic [511:0] RSV_BITS = `IOD_RSV_BITS_DEF,
  parameter logic [63:0] RSV_ADDR = `IOD_RSV_ADDR_DEF
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  iod_if.io bus,
  input wire logic [511:0] flag_set_in,
  output logic [511:0] regs_out,
  output logic [63:0] sel_out,
  output logic wr_stb_out
);

  // ********************************
  // Elaboration checks
  // ********************************
  if (NREG != 64)
    $error("iod_io_end serves exactly 64 registers");
  if ((W1C_MASK & RSV_BITS) != 512'h0)
    $error("iod_io_end: a flag bit cannot be reserved");

  // ********************************
  // Decode
  // ********************************
  logic [511:0] reg_q;
  logic [511:0] next_reg;
  iod_pkg::iod_dec_s dec;
  logic [7:0] cur;
  logic [7:0] bit_mask;
  logic [7:0] wval;
  logic is_wr;
  logic wr_en;
  logic is_skip;
  logic ack_q;
  logic [7:0] rdata_q;
  logic skip_q;
  logic err_q;

  assign dec = iod_pkg::iod_decode(bus.op, bus.addr);
  assign cur = reg_q[{dec.idx, 3'b000} +: 8];
  assign bit_mask = 8'h01 << bus.bitn;
  assign is_wr = iod_pkg::iod_is_write(bus.op);
  assign is_skip = (bus.op == iod_pkg::IOD_SKIP_SET) ||
                   (bus.op == iod_pkg::IOD_SKIP_CLEAR);
  // Bit operations read the whole register and write it back
  assign wval = (bus.op == iod_pkg::IOD_BIT_SET) ? (cur | bit_mask) :
                (bus.op == iod_pkg::IOD_BIT_CLEAR) ? (cur & ~bit_mask) :
                bus.wdata;
  // Writes to reserved addresses are dropped, not stored
  assign wr_en = bus.req && dec.hit && is_wr && !RSV_ADDR[dec.idx];
  assign sel_out = (bus.req && dec.hit) ? (64'h1 << dec.idx) : 64'h0;
  assign wr_stb_out = wr_en;
  assign regs_out = reg_q;

  // ********************************
  // Register bank
  // ********************************
  for (genvar i = 0; i < 64; i++)
  begin : g_reg
    logic hit_i;
    logic [7:0] w1c;
    logic [7:0] old;
    logic [7:0] written;
    assign hit_i = wr_en && (dec.idx == 6'(i));
    assign w1c = W1C_MASK[i*8 +: 8];
    assign old = reg_q[i*8 +: 8];
    // Flags clear on a written one; a set in the same cycle wins
    assign written = hit_i ? ((old & w1c & ~wval) | (wval & ~w1c)) :
                     old;
    assign next_reg[i*8 +: 8] = (written | (flag_set_in[i*8 +: 8] & w1c)) &
                                ~RSV_BITS[i*8 +: 8];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!nrst_in)
      reg_q <= {64{`IOD_RST_VAL}};
    else
      reg_q <= next_reg;
  end

  // ********************************
  // Answer
  // ********************************
  always_ff @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      skip_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      ack_q <= bus.req;
      rdata_q <= dec.hit ? cur : 8'h00;
      skip_q <= bus.req && dec.hit && is_skip &&
                (((cur & bit_mask) != 8'h00) ==
                 (bus.op == iod_pkg::IOD_SKIP_SET));
      err_q <= bus.req && (!dec.hit || (is_wr && RSV_ADDR[dec.idx]));
    end
  end

  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;
  assign bus.skip = skip_q;
  assign bus.err = err_q;

endmodule : iod_io_end

// ===== tb/iod_chk_asserts.sv
// Checker on the channel between the core end and the io end.
// Assumes default masks and one clock shared by both ends.
`timescale 1ns/10ps

module iod_chk_asserts (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic req,
  input wire iod_pkg::iod_op_e op,
  input wire logic [15:0] addr,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic skip,
  input wire logic err,
  input wire logic [63:0] sel,
  input wire logic wr_stb
);
  // ********************************
  // Request decode
  // ********************************
  wire port_op = op inside {iod_pkg::IOD_PORT_IN, iod_pkg::IOD_PORT_OUT};
  wire data_op = op inside {iod_pkg::IOD_DATA_LOAD,
                            iod_pkg::IOD_DATA_STORE};
  // Bit and skip ops sit above the data ops
  wire bit_op = op > iod_pkg::IOD_DATA_STORE;
  wire data_hit = (addr >= 16'h0020) && (addr <= 16'h005f);

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  // ********************************
  // Properties
  // ********************************
  sequence s_idle2;
    !req [*2];
  endsequence
  sequence s_miss;
    err && !skip;
  endsequence

  property p_req_gap;
    req |=> s_idle2;
  endproperty
  a_req_gap: assert property (p_req_gap)
    else $error("request too soon after last");
  property p_ack;
    req |=> ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("no answer one cycle after request");
  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("answer without request");
  property p_port_hit;
    req && port_op && addr <= 16'h003f |=> !err;
  endproperty
  a_port_hit: assert property (p_port_hit)
    else $error("port access in range refused");
  property p_port_miss;
    req && port_op && addr > 16'h003f |=> err && rdata == 8'h00;
  endproperty
  a_port_miss: assert property (p_port_miss)
    else $error("port access out of range accepted");
  property p_data_win;
    req && data_op |=> err == !$past(data_hit);
  endproperty
  a_data_win: assert property (p_data_win)
    else $error("data space window wrong");
  property p_bit_miss;
    req && bit_op && addr > 16'h001f |=> s_miss;
  endproperty
  a_bit_miss: assert property (p_bit_miss)
    else $error("bit op above low range accepted");
  property p_skip_ack;
    skip |-> ack && !err;
  endproperty
  a_skip_ack: assert property (p_skip_ack)
    else $error("skip outside a good answer");
  property p_rsv_read;
    req && op == iod_pkg::IOD_PORT_IN && addr == 16'h003e
      |=> rdata[7:4] == 4'h0;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved bits read nonzero");
  property p_sel_idle;
    !req |-> sel == 64'h0 && !wr_stb;
  endproperty
  a_sel_idle: assert property (p_sel_idle)
    else $error("select or strobe without request");
  property p_sel_port;
    req && port_op && addr <= 16'h003f |-> sel == (64'h1 << addr[5:0]);
  endproperty
  a_sel_port: assert property (p_sel_port)
    else $error("port access selects wrong register");
  property p_sel_data;
    req && data_op && data_hit |-> sel == (64'h1 << 6'(addr - 16'h0020));
  endproperty
  a_sel_data: assert property (p_sel_data)
    else $error("data access selects wrong register");
  property p_stb;
    wr_stb |-> req && $onehot(sel) ##1 ack && !err;
  endproperty
  a_stb: assert property (p_stb)
    else $error("write strobe outside one good access");
endmodule : iod_chk_asserts

// ===== tb/tb_top.sv
// Bench joining the core end and the io end over one channel.
// Assumes the iod sources and header are compiled first.
`timescale 1ns/10ps
`include "iod_cfg.svh"

module tb_top;
  localparam iod_pkg::iod_op_e pin = iod_pkg::IOD_PORT_IN;
  localparam iod_pkg::iod_op_e pout = iod_pkg::IOD_PORT_OUT;
  localparam iod_pkg::iod_op_e ld = iod_pkg::IOD_DATA_LOAD;
  localparam iod_pkg::iod_op_e st = iod_pkg::IOD_DATA_STORE;
  localparam iod_pkg::iod_op_e bs = iod_pkg::IOD_BIT_SET;
  localparam iod_pkg::iod_op_e bc = iod_pkg::IOD_BIT_CLEAR;
  localparam iod_pkg::iod_op_e ss = iod_pkg::IOD_SKIP_SET;
  localparam iod_pkg::iod_op_e sc = iod_pkg::IOD_SKIP_CLEAR;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic valid = 1'b0;
  iod_pkg::iod_op_e cop = pin;
  logic [15:0] caddr = 16'h0000;
  logic [7:0] cwd = 8'h00;
  logic [2:0] cbit = 3'h0;
  logic [511:0] flags = '0;
  logic done;
  logic skp;
  logic erro;
  logic [7:0] rdat;
  logic rdy;
  logic [511:0] regs;
  logic [63:0] sel;
  logic wstb;
  int miscompares = 0;
  int total_checks = 0;

  iod_if bus_if();
  iod_core_end iod_core_end_inst (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .bus(bus_if), .cmd_valid_in(valid),
    .cmd_op_in(cop), .cmd_addr_in(caddr), .cmd_wdata_in(cwd),
    .cmd_bit_in(cbit), .cmd_ready_out(rdy), .done_out(done),
    .rdata_out(rdat), .skip_out(skp), .err_out(erro));
  // Reg 3 gets flags in bits 7:4 so bit ops meet a flag
  iod_io_end #(.W1C_MASK(`IOD_W1C_DEF | (512'hf0 << 24)))
    iod_io_end_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .bus(bus_if), .flag_set_in(flags), .regs_out(regs), .sel_out(sel),
    .wr_stb_out(wstb));
  iod_chk_asserts iod_chk_asserts_inst (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .req(bus_if.req), .op(bus_if.op),
    .addr(bus_if.addr), .ack(bus_if.ack), .rdata(bus_if.rdata),
    .skip(bus_if.skip), .err(bus_if.err), .sel(sel), .wr_stb(wstb));

  // ********************************
  // Tasks
  // ********************************
  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // One command; results hold after done
  task automatic x(input iod_pkg::iod_op_e o, input logic [15:0] a,
                   input logic [7:0] d, input logic [2:0] b,
                   input logic [7:0] er, input logic ee, input logic es);
    int n;
    n = 0;
    @(negedge sys_clk_in);
    valid = 1'b1;
    cop = o;
    caddr = a;
    cwd = d;
    cbit = b;
    @(negedge sys_clk_in);
    valid = 1'b0;
    while (done !== 1'b1 && n < 8)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    chk("done", 8'h01, {7'h00, done});
    chk("ready", 8'h01, {7'h00, rdy});
    if (o == pin || o == ld)
      chk("rdata", er, rdat);
    chk("err", {7'h00, ee}, {7'h00, erro});
    chk("skip", {7'h00, es}, {7'h00, skp});
  endtask : x

  // ********************************
  // Clock, watchdog, tests
  // ********************************
  initial
  begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  initial
  begin
    repeat (1000) @(posedge sys_clk_in);
    miscompares++;
    end_sim();
  end

  initial
  begin
    repeat (3) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    x(pin, 16'h0005, 8'h00, 3'h0, 8'h00, 0, 0);
    x(pout, 16'h0005, 8'ha5, 3'h0, 8'h00, 0, 0);
    x(pin, 16'h0005, 8'h00, 3'h0, 8'ha5, 0, 0);
    x(ld, 16'h0025, 8'h00, 3'h0, 8'ha5, 0, 0);
    x(st, 16'h005e, 8'hff, 3'h0, 8'h00, 0, 0);
    x(pin, 16'h003e, 8'h00, 3'h0, 8'h0f, 0, 0);
    x(ld, 16'h001f, 8'h00, 3'h0, 8'h00, 1, 0);
    x(pin, 16'h0040, 8'h00, 3'h0, 8'h00, 1, 0);
    x(bs, 16'h0005, 8'h00, 3'h1, 8'h00, 0, 0);
    x(bc, 16'h0005, 8'h00, 3'h0, 8'h00, 0, 0);
    x(pin, 16'h0005, 8'h00, 3'h0, 8'ha6, 0, 0);
    x(bs, 16'h0020, 8'h00, 3'h0, 8'h00, 1, 0);
    x(pin, 16'h0020, 8'h00, 3'h0, 8'h00, 0, 0);
    x(ss, 16'h0005, 8'h00, 3'h2, 8'h00, 0, 1);
    x(sc, 16'h0005, 8'h00, 3'h2, 8'h00, 0, 0);
    x(sc, 16'h0005, 8'h00, 3'h0, 8'h00, 0, 1);
    x(ss, 16'h0021, 8'h00, 3'h0, 8'h00, 1, 0);
    x(pout, 16'h0000, 8'h55, 3'h0, 8'h00, 1, 0);
    x(pin, 16'h0000, 8'h00, 3'h0, 8'h00, 0, 0);
    @(negedge sys_clk_in);
    flags[61*8 +: 8] = 8'hf0;
    flags[3*8 +: 8] = 8'h80;
    @(negedge sys_clk_in);
    flags = '0;
    x(pin, 16'h003d, 8'h00, 3'h0, 8'hf0, 0, 0);
    x(pout, 16'h003d, 8'h30, 3'h0, 8'h00, 0, 0);
    x(pin, 16'h003d, 8'h00, 3'h0, 8'hc0, 0, 0);
    x(pout, 16'h0003, 8'h01, 3'h0, 8'h00, 0, 0);
    x(pin, 16'h0003, 8'h00, 3'h0, 8'h81, 0, 0);
    x(bs, 16'h0003, 8'h00, 3'h1, 8'h00, 0, 0);
    x(pin, 16'h0003, 8'h00, 3'h0, 8'h03, 0, 0);
    chk("reg3", 8'h03, regs[3*8 +: 8]);
    chk("reg62", 8'h0f, regs[62*8 +: 8]);
    chk("reg0", 8'h00, regs[7:0]);
    end_sim();
  end
endmodule : tb_top
